// file: hdl/pcrc_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module pcrc_buffer
   import pcrc_pkg::*;
#(
   parameter int WIDTH = 36,
   parameter int DEPTH = 2
)(
   input  wire logic                     clk,      // System clock
   input  wire logic                     nrst,     // Sync reset, active low
   input  wire logic                     inValid,  // Writer offers a word
   output logic                          inReady,  // Room for a word
   input  wire logic [WIDTH-1:0]         inData,   // Word in
   output logic                          outValid, // Word waiting
   input  wire logic                     outReady, // Reader takes it
   output logic [WIDTH-1:0]              outData,  // Oldest word
   output logic [$clog2(DEPTH+1)-1:0]    level     // Words held
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int LW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0]             store [DEPTH];
   logic [PW-1:0]                wrPtr;
   logic [PW-1:0]                rdPtr;
   wire                          doPush = inValid & inReady;
   wire                          doPop  = outValid & outReady;

   // Honest flags straight from the fill level
   assign inReady  = (level != LW'(DEPTH));
   assign outValid = (level != '0);
   assign outData  = store[rdPtr];

   // Pointer wrap works for any depth, not only powers of two
   always_ff @(posedge clk) begin
      if (!nrst) begin
         wrPtr <= '0;
         rdPtr <= '0;
         level <= '0;
      end else begin
         if (doPush) wrPtr <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
         if (doPop)  rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
         level <= level + LW'(doPush) - LW'(doPop);
      end
   end

   // Storage has no reset; level guards stale contents
   always_ff @(posedge clk) begin
      if (doPush) store[wrPtr] <= inData;
   end

endmodule : pcrc_buffer
`default_nettype wire

// file: hdl/pcrc_engine.sv
// How it works
// - Seed write restarts checksum from seed
// - Seed takes 16 or 32 bits per width
// - Writable polynomial register drives calculation
// - Polynomial MSB first, top term implied
// - Width select sets register and degree
// - Optional complement of read-back checksum
// - Written bytes pass input transpose first
// - Data read returns transposed, optionally complemented checksum
// - Four transpose choices for each direction
// - Input and output transposes set separately
// - Sixteen-bit mode reads a 16-bit result
// - Settings cover common CRC16 and CRC32 flavours
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pcrc_engine
   import pcrc_pkg::*;
#(
   parameter int BUF_DEPTH = 2
)(
   input  wire logic              clk,     // 50 MHz system clock
   input  wire logic              nrst,    // Sync reset, active low
   input  wire logic              psel,    // APB select
   input  wire logic              penable, // APB access phase
   input  wire logic              pwrite,  // APB direction
   input  wire logic [ADDR_W-1:0] paddr,   // APB byte address
   input  wire logic [31:0]       pwdata,  // APB write data
   input  wire logic [3:0]        pstrb,   // APB byte strobes
   output logic      [31:0]       prdata,  // APB read data
   output logic                   pready,  // APB ready
   output logic                   pslverr  // APB error, unmapped
);

   localparam int LW = $clog2(BUF_DEPTH + 1);

   pcrc_bus_type       busState;
   pcrc_bus_type       next_busState;
   pcrc_cfg_type       cfg;
   logic [31:0]        genPoly;
   logic [31:0]        startVal;
   logic [31:0]        crcState;
   logic [31:0]        curWord;
   logic [3:0]         curStrb;

   pcrc_entry_type     bufIn;
   pcrc_entry_type     bufOut;
   logic               bufInReady;
   logic               bufOutValid;
   logic [LW-1:0]      bufLevel;

   // Fold one byte into the running checksum, MSB of the byte first
   function automatic logic [31:0] pcrc_crc_byte(logic [31:0] c, logic [7:0] d,
                                                 logic [31:0] p, pcrc_width_type w);
      logic [31:0] r;
      logic        fb;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         fb = ((w == width_thirtytwo) ? r[31] : r[15]) ^ d[i];
         r  = {r[30:0], 1'b0};
         if (fb) r = r ^ p;
      end
      return (w == width_thirtytwo) ? r : (r & MASK16);
   endfunction : pcrc_crc_byte

   // Address decode; misaligned or unknown offsets are unmapped
   wire hitData = (paddr == OFS_DATA);
   wire hitPoly = (paddr == OFS_POLY);
   wire hitSeed = (paddr == OFS_SEED);
   wire hitCtrl = (paddr == OFS_CTRL);
   wire hitStat = (paddr == OFS_STAT);
   wire hitAny  = hitData | hitPoly | hitSeed | hitCtrl | hitStat;

   // Engine is busy while any byte is still waiting to be folded in
   wire engineBusy = bufOutValid | (curStrb != 4'h0);
   wire bufOutReady = (curStrb == 4'h0);

   // Data writes need buffer room; unmapped accesses go at once; every other access waits for a drained engine
   wire canGo = !hitAny ? 1'b1 :
                (hitData & pwrite) ? bufInReady : !engineBusy;
   wire setup      = psel & penable;
   wire goDone     = (busState != BUS_DONE) & setup & canGo;
   wire accessDone = (busState == BUS_DONE) & setup;
   wire wrDone     = accessDone & pwrite;

   wire [31:0] widthMask = (cfg.checksum_width_sel == width_thirtytwo) ? MASK32 : MASK16;

   wire [31:0] orderedOut = pcrc_reorder(crcState & widthMask, cfg.output_reorder_sel,
                                         cfg.checksum_width_sel);
   wire [31:0] resultVal  = orderedOut ^ (cfg.invert_result_en ? widthMask : 32'h0000_0000);

   wire [31:0] ctrlWord = {26'h0, cfg.output_reorder_sel, cfg.input_reorder_sel,
                           cfg.invert_result_en, cfg.checksum_width_sel};
   wire [31:0] statWord = {{(32 - STAT_LVL_LSB - LW){1'b0}}, bufLevel,
                           {(STAT_LVL_LSB - 1){1'b0}}, engineBusy};
   wire [31:0] readMux  = hitData ? resultVal :
                          hitPoly ? genPoly   :
                          hitSeed ? startVal  :
                          hitCtrl ? ctrlWord  :
                          hitStat ? statWord  : 32'h0000_0000;

   // input transpose on the whole written word
   wire byteMove = (cfg.input_reorder_sel == transpose_full_reverse) |
                   (cfg.input_reorder_sel == transpose_byte_swap);
   assign bufIn.data = pcrc_reorder(pwdata, cfg.input_reorder_sel, width_thirtytwo);
   // Strobes follow their bytes when lanes are swapped
   assign bufIn.strb = byteMove ? {pstrb[0], pstrb[1], pstrb[2], pstrb[3]} : pstrb;
   wire   pushData   = wrDone & hitData & (pstrb != 4'h0);

   // highest lane is the earliest message byte
   wire [1:0] lane = curStrb[3] ? 2'd3 : curStrb[2] ? 2'd2 : curStrb[1] ? 2'd1 : 2'd0;
   wire [7:0] laneByte = curWord[8*lane +: 8];
   wire [31:0] next_crc = pcrc_crc_byte(crcState, laneByte, genPoly & widthMask,
                                        cfg.checksum_width_sel);

   // Two-entry buffer absorbs writes while the engine walks lanes
   pcrc_buffer #(
      .WIDTH    ($bits(pcrc_entry_type)),
      .DEPTH    (BUF_DEPTH)
   ) pcrc_buffer_i (
      .clk      (clk),
      .nrst     (nrst),
      .inValid  (pushData),
      .inReady  (bufInReady),
      .inData   (bufIn),
      .outValid (bufOutValid),
      .outReady (bufOutReady),
      .outData  (bufOut),
      .level    (bufLevel)
   );

   // Bus sequencer: stretch the access phase until the request can go
   always_comb begin
      next_busState = busState;
      unique case (busState)
         BUS_IDLE: begin
            if (setup) next_busState = canGo ? BUS_DONE : BUS_HOLD;
         end
         BUS_HOLD: begin
            if (!setup)     next_busState = BUS_IDLE;
            else if (canGo) next_busState = BUS_DONE;
         end
         BUS_DONE: begin
            next_busState = BUS_IDLE;
         end
         default: next_busState = BUS_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) busState <= BUS_IDLE;
      else       busState <= next_busState;
   end

   // Answer flops; read data captured when ready is raised
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= goDone;
         pslverr <= goDone & !hitAny;
         prdata  <= (goDone & !pwrite) ? readMux : 32'h0000_0000;
      end
   end

   // Configuration writes take effect on the completing edge
   // one field set covers the usual flavours
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cfg     <= '0;
         genPoly <= RST_POLY;
      end else if (wrDone) begin
         if (hitPoly) genPoly <= pcrc_merge(genPoly, pwdata, pstrb);
         if (hitCtrl & pstrb[0]) cfg <= pcrc_cfg_type'(pwdata[5:0]);
      end
   end

   // Checksum state: seed load wins, else one lane per cycle
   always_ff @(posedge clk) begin
      if (!nrst) begin
         crcState <= RST_SEED;
         startVal <= RST_SEED;
         curWord  <= 32'h0000_0000;
         curStrb  <= 4'h0;
      end else if (wrDone & hitSeed) begin
         startVal <= pcrc_merge(32'h0000_0000, pwdata, pstrb) & widthMask;
         crcState <= pcrc_merge(32'h0000_0000, pwdata, pstrb) & widthMask;
      end else if (curStrb != 4'h0) begin
         crcState      <= next_crc;
         curStrb[lane] <= 1'b0;
      end else if (bufOutValid) begin
         curWord <= bufOut.data;
         curStrb <= bufOut.strb;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   wire rdDataDone = (busState == BUS_DONE) & setup & !pwrite & hitData;

   // Full-word seed lands in the checksum
   property p_seed_load;
      (wrDone && hitSeed && pstrb == 4'hF) |=> (crcState == ($past(pwdata) & $past(widthMask)));
   endproperty
   a_seed_load: assert property (p_seed_load) else $error("seed not loaded");

   // Full-word polynomial is stored as written
   property p_poly_kept;
      (wrDone && hitPoly && pstrb == 4'hF) |=> (genPoly == $past(pwdata));
   endproperty
   a_poly_kept: assert property (p_poly_kept) else $error("polynomial not stored");

   // Width bit follows the control write
   property p_width_sel;
      (wrDone && hitCtrl && pstrb[0])
         |=> (cfg.checksum_width_sel == $past(pwdata[CTRL_WIDTH_BIT]));
   endproperty
   a_width_sel: assert property (p_width_sel) else $error("width select lost");

   // Complement without reorder
   property p_invert;
      (rdDataDone && cfg.invert_result_en && cfg.output_reorder_sel == transpose_off)
         |-> (prdata == ((crcState ^ widthMask) & widthMask));
   endproperty
   a_invert: assert property (p_invert) else $error("complement wrong");

   // A loaded word is used up within five cycles
   property p_drain;
      (bufOutValid && bufOutReady) |-> ##[1:5] (curStrb == 4'h0);
   endproperty
   a_drain: assert property (p_drain) else $error("bytes not folded in time");

   // Data read answers only once drained
   property p_read_idle;
      (goDone && hitData && !pwrite) |-> !engineBusy;
   endproperty
   a_read_idle: assert property (p_read_idle) else $error("read before drain");

   // Byte swap alone on a wide result
   property p_byte_swap;
      (rdDataDone && !cfg.invert_result_en && cfg.output_reorder_sel == transpose_byte_swap
       && cfg.checksum_width_sel == width_thirtytwo)
         |-> (prdata == {crcState[7:0], crcState[15:8], crcState[23:16], crcState[31:24]});
   endproperty
   a_byte_swap: assert property (p_byte_swap) else $error("byte swap wrong");

   // Narrow mode keeps the upper half clear
   property p_narrow;
      (rdDataDone && cfg.checksum_width_sel == width_sixteen) |-> (prdata[31:16] == 16'h0000);
   endproperty
   a_narrow: assert property (p_narrow) else $error("16-bit result too wide");

   // Ready is a single-cycle pulse
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held over one cycle");

   // Settings move only on a control write
   property p_cfg_hold;
      !(wrDone && hitCtrl && pstrb[0]) |=> $stable(cfg);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("settings changed unasked");

   // Polynomial moves only on its own write
   property p_poly_hold;
      !(wrDone && hitPoly) |=> $stable(genPoly);
   endproperty
   a_poly_hold: assert property (p_poly_hold) else $error("polynomial changed unasked");

   // Any seed write restarts from the stored seed
   property p_seed_restart;
      (wrDone && hitSeed) |=> (crcState == startVal);
   endproperty
   a_seed_restart: assert property (p_seed_restart) else $error("no restart on seed");

   // Narrow seed has no upper half
   property p_seed_narrow;
      (wrDone && hitSeed && cfg.checksum_width_sel == width_sixteen)
         |=> (startVal[31:16] == 16'h0000);
   endproperty
   a_seed_narrow: assert property (p_seed_narrow) else $error("narrow seed too wide");

   // Every pending lane folds one byte per cycle
   property p_fold_step;
      (curStrb != 4'h0) |=> (crcState == $past(next_crc));
   endproperty
   a_fold_step: assert property (p_fold_step) else $error("byte step skipped");

   // The highest pending lane goes first
   property p_top_lane;
      (curStrb != 4'h0) |-> ((curStrb >> lane) == 4'h1);
   endproperty
   a_top_lane: assert property (p_top_lane) else $error("lane order wrong");

   // Popped word is the one the engine walks
   property p_word_load;
      (bufOutValid && bufOutReady) |=> (curWord == $past(bufOut.data));
   endproperty
   a_word_load: assert property (p_word_load) else $error("buffered word lost");

   // Narrow folding leaves the upper half clear
   property p_narrow_state;
      (curStrb != 4'h0 && cfg.checksum_width_sel == width_sixteen)
         |=> (crcState[31:16] == 16'h0000);
   endproperty
   a_narrow_state: assert property (p_narrow_state) else $error("narrow degree wrong");

   // Read data is quiet outside the answer cycle
   property p_rdata_quiet;
      !pready |-> (prdata == 32'h0000_0000);
   endproperty
   a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside answer");

   // Error only ever comes with ready
   property p_error_pair;
      pslverr |-> pready;
   endproperty
   a_error_pair: assert property (p_error_pair) else $error("error without ready");

   // Unmapped places answer at once with an error
   property p_unmapped_fast;
      (setup && !hitAny && busState != BUS_DONE) |=> (pready && pslverr);
   endproperty
   a_unmapped_fast: assert property (p_unmapped_fast) else $error("unmapped access not refused");

   // Full buffer stretches a data write, never drops it
   property p_data_stall;
      (setup && hitData && pwrite && !bufInReady && busState != BUS_DONE) |=> !pready;
   endproperty
   a_data_stall: assert property (p_data_stall) else $error("write taken into full buffer");

endmodule : pcrc_engine
`default_nettype wire

// file: include/pcrc_pkg.sv
`default_nettype none
package pcrc_pkg;

   // Register byte offsets on the APB window
   localparam int            ADDR_W   = 8;
   localparam logic [7:0]    OFS_DATA = 8'h00;
   localparam logic [7:0]    OFS_POLY = 8'h04;
   localparam logic [7:0]    OFS_SEED = 8'h08;
   localparam logic [7:0]    OFS_CTRL = 8'h0C;
   localparam logic [7:0]    OFS_STAT = 8'h10;

   // Control register field positions
   localparam int            CTRL_WIDTH_BIT = 0;
   localparam int            CTRL_INV_BIT   = 1;
   localparam int            CTRL_IN_LSB    = 2;
   localparam int            CTRL_OUT_LSB   = 4;

   // Status register field positions
   localparam int            STAT_BUSY_BIT  = 0;
   localparam int            STAT_LVL_LSB   = 4;

   // Values after reset
   localparam logic [31:0]   RST_POLY = 32'h0000_1021;
   localparam logic [31:0]   RST_SEED = 32'h0000_0000;

   // Width masks for the two checksum sizes
   localparam logic [31:0]   MASK16 = 32'h0000_FFFF;
   localparam logic [31:0]   MASK32 = 32'hFFFF_FFFF;

   typedef enum logic [1:0] {
      transpose_off         = 2'h0,
      transpose_bit_reverse = 2'h1,
      transpose_full_reverse = 2'h2,
      transpose_byte_swap   = 2'h3
   } pcrc_reorder_type;

   typedef enum logic {
      width_sixteen   = 1'b0,
      width_thirtytwo = 1'b1
   } pcrc_width_type;

   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_HOLD = 3'b010,
      BUS_DONE = 3'b100
   } pcrc_bus_type;

   typedef struct packed {
      pcrc_reorder_type output_reorder_sel;
      pcrc_reorder_type input_reorder_sel;
      logic             invert_result_en;
      pcrc_width_type   checksum_width_sel;
   } pcrc_cfg_type;

   typedef struct packed {
      logic [31:0] data;
      logic [3:0]  strb;
   } pcrc_entry_type;

   // Bit reversal within bytes and/or byte reversal of a word
   function automatic logic [31:0] pcrc_reorder(logic [31:0] v, pcrc_reorder_type sel,
                                                pcrc_width_type w);
      logic [31:0] bits;
      logic [31:0] x;
      for (int i = 0; i < 32; i++) begin
         bits[i] = v[(i & ~7) + 7 - (i & 7)];
      end
      x = (sel == transpose_bit_reverse || sel == transpose_full_reverse) ? bits : v;
      if (sel == transpose_full_reverse || sel == transpose_byte_swap) begin
         x = (w == width_thirtytwo) ? {x[7:0], x[15:8], x[23:16], x[31:24]}
                                    : {16'h0000, x[7:0], x[15:8]};
      end
      return x;
   endfunction : pcrc_reorder

   // Byte-lane merge under APB strobes
   function automatic logic [31:0] pcrc_merge(logic [31:0] old, logic [31:0] nw,
                                              logic [3:0] strb);
      logic [31:0] r;
      for (int i = 0; i < 4; i++) begin
         r[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
      end
      return r;
   endfunction : pcrc_merge

endpackage : pcrc_pkg
`default_nettype wire

// file: verification/tb_pcrc_engine.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pcrc_engine
   import pcrc_pkg::*;
();

   logic              clk = 1'b0;
   logic              chain = 1'b0;
   logic              nrst;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata;
   logic [3:0]        pstrb;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic [31:0]       rdData;
   logic              rdErr;
   logic [31:0]       mCrc;
   logic [31:0]       mPoly;
   logic [5:0]        mCtrl;
   logic [127:0]      known [5];
   int                errors;
   int                check_count;

   pcrc_engine #(.BUF_DEPTH(2)) pcrc_engine_i (
      .clk     (clk),
      .nrst    (nrst),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .pstrb   (pstrb),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr)
   );

   // 50 MHz clock
   always #10 clk = ~clk;

   // Own reorder copy, so a shared bug cannot hide
   function automatic logic [31:0] reorder(input logic [31:0] v, input logic [1:0] sel,
                                           input logic half);
      logic [31:0] x;
      for (int i = 0; i < 32; i++) x[i] = v[(i & ~7) + 7 - (i & 7)];
      if (sel == 2'h0 || sel == 2'h3) x = v;
      if (sel[1]) x = half ? {16'h0000, x[7:0], x[15:8]} : {x[7:0], x[15:8], x[23:16], x[31:24]};
      return x;
   endfunction : reorder

   function automatic logic [31:0] wmask();
      return mCtrl[0] ? 32'hFFFF_FFFF : 32'h0000_FFFF;
   endfunction : wmask

   function automatic logic [31:0] result();
      return reorder(mCrc & wmask(), mCtrl[5:4], ~mCtrl[0]) ^ (mCtrl[1] ? wmask() : 32'h0);
   endfunction : result

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   // One APB transfer; with chain set the next setup follows the completion edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 500);
      rdData = prdata;
      rdErr = pslverr;
      if (n >= 500) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      end
      if (!chain) begin
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge clk);
      end
   endtask : bus

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000, 4'h0);
      cmp(rdData, exp);
      cmp({31'h0, rdErr}, 32'h0000_0000);
   endtask : rd

   // Model folds strobed lanes, top lane first
   task automatic feed(input logic [31:0] d, input logic [3:0] s);
      logic [31:0] w;
      logic [3:0]  m;
      logic        fb;
      bus(1'b1, OFS_DATA, d, s);
      w = reorder(d, mCtrl[3:2], 1'b0);
      m = mCtrl[3] ? {s[0], s[1], s[2], s[3]} : s;
      for (int l = 3; l >= 0; l--) begin
         for (int b = 7; b >= 0; b--) begin
            fb = (mCtrl[0] ? mCrc[31] : mCrc[15]) ^ w[8*l+b];
            if (m[l]) mCrc = ((mCrc << 1) ^ (fb ? mPoly : 32'h0)) & wmask();
         end
      end
   endtask : feed

   task automatic cfg(input logic [5:0] c, input logic [31:0] p, input logic [31:0] s);
      bus(1'b1, OFS_CTRL, {26'h0, c}, 4'hF);
      bus(1'b1, OFS_POLY, p, 4'hF);
      bus(1'b1, OFS_SEED, s, 4'hF);
      mCtrl = c;
      mPoly = p;
      mCrc = s & wmask();
   endtask : cfg

   // Hang guard, far beyond the expected few thousand cycles
   initial begin
      #(20 * 40000);
      errors++;
      end_sim();
   end

   initial begin
      nrst = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      errors = 0;
      check_count = 0;
      known[0] = {32'h00, 32'h0000_1021, 32'h0000_FFFF, 32'h0000_29B1};
      known[1] = {32'h24, 32'h0000_1021, 32'h0000_0000, 32'h0000_2189};
      known[2] = {32'h26, 32'h0000_8005, 32'h0000_0000, 32'h0000_44C2};
      known[3] = {32'h27, 32'h04C1_1DB7, 32'hFFFF_FFFF, 32'hCBF4_3926};
      known[4] = {32'h03, 32'h04C1_1DB7, 32'h0000_0000, 32'h765E_7680};
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      // Reset values
      rd(OFS_POLY, RST_POLY);
      rd(OFS_SEED, RST_SEED);
      rd(OFS_CTRL, 32'h0000_0000);
      rd(OFS_STAT, 32'h0000_0000);
      rd(OFS_DATA, 32'h0000_0000);
      $display("test reset done");
      // Unmapped, misaligned and read-only places
      bus(1'b0, 8'h14, 32'h0000_0000, 4'h0);
      cmp({31'h0, rdErr}, 32'h0000_0001);
      cmp(rdData, 32'h0000_0000);
      bus(1'b1, 8'h02, 32'hFFFF_FFFF, 4'hF);
      cmp({31'h0, rdErr}, 32'h0000_0001);
      bus(1'b1, OFS_STAT, 32'hFFFF_FFFF, 4'hF);
      cmp({31'h0, rdErr}, 32'h0000_0000);
      rd(OFS_STAT, 32'h0000_0000);
      // Thirty-two-bit width, then partial seed strobe
      bus(1'b1, OFS_CTRL, 32'h0000_0001, 4'hF);
      bus(1'b1, OFS_SEED, 32'hDEAD_BEEF, 4'h3);
      rd(OFS_SEED, 32'h0000_BEEF);
      $display("test map done");
      // Common flavours over the check string, first byte in the top lane
      for (int k = 0; k < 5; k++) begin
         cfg(known[k][101:96], known[k][95:64], known[k][63:32]);
         feed(32'h3132_3334, 4'hF);
         rd(OFS_DATA, result());
         feed(32'h3536_3738, 4'hF);
         feed(32'h3900_0000, 4'h8);
         rd(OFS_DATA, result());
         if (known[k][31:0] != 32'h0) cmp(rdData, known[k][31:0]);
      end
      $display("test flavours done");
      // Every transpose pair in both widths, invert on odd input codes
      for (int c = 0; c < 32; c++) begin
         cfg({c[3:2], c[1:0], c[0], c[4]}, 32'h04C1_1DB7, 32'h1234_5678);
         rd(OFS_SEED, mCrc);
         feed(32'hA1B2_C3D4, 4'hF);
         feed(32'h5E6F_7081, 4'h5);
         rd(OFS_DATA, result());
         if (!c[4]) cmp(rdData & 32'hFFFF_0000, 32'h0000_0000);
      end
      $display("test transpose done");
      // Burst of writes so the buffer fills and stalls
      cfg(6'h01, 32'h04C1_1DB7, 32'hFFFF_FFFF);
      // Chained writes outpace the engine, so the buffer fills and stalls the bus
      for (int i = 0; i < 6; i++) begin
         chain = (i < 5);
         feed(32'h0102_0304 * (i + 1), 4'hF);
      end
      rd(OFS_DATA, result());
      cfg(6'h01, 32'h04C1_1DB7, 32'hFFFF_FFFF);
      rd(OFS_DATA, 32'hFFFF_FFFF);
      $display("test burst done");
      end_sim();
   end

endmodule : tb_pcrc_engine
`default_nettype wire
